// *** design/ptt_consts.svh ***
/*
 Constants of the package thermal throttle: register indices, field
 positions, reset values and timing counts.
 Assumes a 50 MHz reference clock; the including file supplies nothing else.
*/
`ifndef PTT_CONSTS_SVH
`define PTT_CONSTS_SVH

`define PTT_IDX_CORE_STAT   12'h19c
`define PTT_IDX_TEMP_TGT    12'h1a2
`define PTT_IDX_PKG_STAT    12'h1b1

`define PTT_B_HOT           0
`define PTT_B_HOT_LOG       1
`define PTT_B_OOS           4
`define PTT_B_OOS_LOG       5
`define PTT_B_THR1          6
`define PTT_B_THR1_LOG      7
`define PTT_B_THR2          8
`define PTT_B_THR2_LOG      9
`define PTT_B_RD_LO         16
`define PTT_B_RD_HI         22
`define PTT_B_VALID         31
`define PTT_B_TJ_LO         16
`define PTT_B_TJ_HI         23

`define PTT_TJ_MAX          8'h64
`define PTT_RATIO_MAX       6'h28
`define PTT_RATIO_MIN       6'h08
`define PTT_VC_BASE         8'h20

`define PTT_CLK_NS          20
`define PTT_MOD_PERIOD_NS   32000
`define PTT_MOD_CYC         (`PTT_MOD_PERIOD_NS / `PTT_CLK_NS)
`define PTT_MOD_ON_CYC      (`PTT_MOD_CYC / 4)
`define PTT_VSTEP_NS        1000
`define PTT_VSTEP_CYC       (`PTT_VSTEP_NS / `PTT_CLK_NS)
`define PTT_FSTALL_NS       200
`define PTT_FSTALL_CYC      (`PTT_FSTALL_NS / `PTT_CLK_NS)
`define PTT_ADAPT_NS        20000
`define PTT_ADAPT_CYC       (`PTT_ADAPT_NS / `PTT_CLK_NS)
`define PTT_HYST_NS         10000
`define PTT_HYST_CYC        (`PTT_HYST_NS / `PTT_CLK_NS)
`define PTT_AVG_WIN_MS      256
`define PTT_AVG_SAMPLES     256
`define PTT_AVG_SAMPLE_CYC  (`PTT_AVG_WIN_MS * 50000 / `PTT_AVG_SAMPLES)

`endif

// *** design/ptt_pkg.sv ***
/*
 Types of the package thermal throttle.
 Assumes ptt_consts.svh for all numeric constants.
*/
package ptt_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_VUP  = 2'b01,
      ST_FREQ = 2'b10,
      ST_VDN  = 2'b11
   } ptt_op_state_t;

endpackage : ptt_pkg

// *** design/ptt_throttle.sv ***
/*
 Package thermal throttle: activation compare, operating point sequencer
 with voltage step codes, fixed duty clock modulation, status registers,
 threshold events and the averaged sideband temperature.
 Assumes sensor readings and performance requests come from logic on
 ref_clk_in, and that the regulator takes one code per strobe.
*/
// Behaviour
// R01: Reaching limit activates control, asserts hot
// R02: Activation offset lowers engage temperature
// R03: Control stays engaged while temperature exceeds limit
// R04: Protection can never be disabled
// R05: Limit temperature read-only in bits 23:16
// R06: Return to normal point with hysteresis
// R07: Upward change: voltage before frequency
// R08: Downward change: frequency before voltage
// R09: Voltage moves in single 5 mV codes
// R10: Regulator accepts dynamic code steps
// R11: Stall execution only during frequency change
// R12: Defer requests above thermal target
// R13: Apply requests below thermal target immediately
// R14: Modulate clocks once at minimum point
// R15: Modulation duty 25% on, 75% off
// R16: Modulation period 32 us, frequency independent
// R17: Stop only below limit after hysteresis
// R18: Snoops and interrupts continue while throttled
// R19: Register instantaneous, sideband 256 ms average
// R20: Readout relative below limit, never above
// R21: Reading zero without offset activates control
// R22: Two programmable thresholds raise interrupts
// R23: Sticky logs until software clears them
`timescale 1ns/1ns
`include "ptt_consts.svh"

module ptt_throttle #(
   parameter int AVG_SAMPLE_CYC = `PTT_AVG_SAMPLE_CYC
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [6:0]  core_rel_temp_in,
   input  wire logic [6:0]  gfx_rel_temp_in,
   input  wire logic [6:0]  act_offset_in,
   input  wire logic [6:0]  thr1_in,
   input  wire logic [6:0]  thr2_in,
   input  wire logic        pstate_req_in,
   input  wire logic [5:0]  pstate_ratio_in,
   input  wire logic        msr_rd_in,
   input  wire logic        msr_wr_in,
   input  wire logic [11:0] msr_idx_in,
   input  wire logic [63:0] msr_wdata_in,
   output logic [63:0]      msr_rdata_out,
   output logic             msr_ack_out,
   output logic             msr_err_out,
   output logic             package_hot_n_out,
   output logic             ctl_active_out,
   output logic [5:0]       ratio_out,
   output logic [7:0]       voltage_step_code_out,
   output logic             vcode_strobe_out,
   output logic             core_stall_out,
   output logic             clk_run_out,
   output logic             pstate_deferred_out,
   output logic             thr_int_out,
   output logic [6:0]       sideband_temp_out
);

   localparam int MOD_CYC  = `PTT_MOD_CYC;
   localparam int ON_CYC   = `PTT_MOD_ON_CYC;
   localparam int VST_CYC  = `PTT_VSTEP_CYC;
   localparam int FST_CYC  = `PTT_FSTALL_CYC;
   localparam int ADP_CYC  = `PTT_ADAPT_CYC;
   localparam int HYS_CYC  = `PTT_HYST_CYC;

   function automatic logic [7:0] vc_of(input logic [5:0] r);
      vc_of = `PTT_VC_BASE + {1'b0, r, 1'b0};
   endfunction : vc_of

   logic [6:0]  pkg_rel;
   logic        hot;
   logic        hot_r;
   logic        ctl_r;
   logic [15:0] hyst_cnt_r;
   logic [15:0] adp_cnt_r;
   logic [5:0]  therm_ratio_r;
   logic [5:0]  os_ratio_r;
   logic [5:0]  tgt;
   logic [5:0]  tgt_r;
   logic [5:0]  ratio_r;
   logic [7:0]  vcode_r;
   logic        vstb_r;
   logic [15:0] step_cnt_r;
   logic        mod_en;
   logic [10:0] mod_cnt_r;
   logic        clk_run_r;
   logic [3:0]  core_st;
   logic [3:0]  pkg_st;
   logic [3:0]  core_prev_r;
   logic [3:0]  pkg_prev_r;
   logic [3:0]  core_log_r;
   logic [3:0]  pkg_log_r;
   logic [3:0]  core_clr;
   logic [3:0]  pkg_clr;
   logic        thr_int_r;
   logic [31:0] smp_cnt_r;
   logic [7:0]  smp_idx_r;
   logic [14:0] acc_r;
   logic [6:0]  avg_r;
   logic [63:0] rdata_nxt;
   logic        err_nxt;
   logic [63:0] rdata_r;
   logic        ack_r;
   logic        err_r;
   ptt_pkg::ptt_op_state_t st_r;

   // Package reading is the hottest sensor, the smallest relative value
   assign pkg_rel = (core_rel_temp_in < gfx_rel_temp_in) ?
                    core_rel_temp_in : gfx_rel_temp_in;
   // No enable term exists anywhere on this path
   assign hot = (pkg_rel <= act_offset_in); // R01 R02 R04 R21

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hot_r <= 1'b0;
      end else begin
         hot_r <= hot; // R01
      end
   end

   // Engagement and hysteresis timer
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctl_r      <= 1'b0;
         hyst_cnt_r <= 16'h0000;
      end else if (hot_r) begin
         ctl_r      <= 1'b1; // R01 R03
         hyst_cnt_r <= 16'h0000;
      end else if (ctl_r) begin
         if (hyst_cnt_r == 16'(HYS_CYC - 1)) begin
            ctl_r      <= 1'b0; // R17 R06
            hyst_cnt_r <= 16'h0000;
         end else begin
            hyst_cnt_r <= hyst_cnt_r + 16'h0001;
         end
      end
   end

   // Thermal target walks down one ratio per interval while hot
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         therm_ratio_r <= `PTT_RATIO_MAX;
         adp_cnt_r     <= 16'h0000;
      end else if (!ctl_r) begin
         therm_ratio_r <= `PTT_RATIO_MAX; // R06
         adp_cnt_r     <= 16'h0000;
      end else if (hot_r) begin
         if (adp_cnt_r == 16'(ADP_CYC - 1)) begin
            adp_cnt_r <= 16'h0000;
            if (therm_ratio_r > `PTT_RATIO_MIN) begin
               therm_ratio_r <= therm_ratio_r - 6'h01; // R03
            end
         end else begin
            adp_cnt_r <= adp_cnt_r + 16'h0001;
         end
      end
   end

   // Requests are clamped into the supported range
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         os_ratio_r <= `PTT_RATIO_MAX;
      end else if (pstate_req_in) begin
         if (pstate_ratio_in > `PTT_RATIO_MAX) begin
            os_ratio_r <= `PTT_RATIO_MAX;
         end else if (pstate_ratio_in < `PTT_RATIO_MIN) begin
            os_ratio_r <= `PTT_RATIO_MIN;
         end else begin
            os_ratio_r <= pstate_ratio_in;
         end
      end
   end

   // A higher request waits, a lower one wins at once
   assign tgt = (ctl_r && os_ratio_r > therm_ratio_r) ?
                therm_ratio_r : os_ratio_r; // R12 R13

   // Operating point sequencer
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r       <= ptt_pkg::ST_IDLE;
         tgt_r      <= `PTT_RATIO_MAX;
         ratio_r    <= `PTT_RATIO_MAX;
         vcode_r    <= `PTT_VC_BASE + {1'b0, `PTT_RATIO_MAX, 1'b0};
         vstb_r     <= 1'b0;
         step_cnt_r <= 16'h0000;
      end else begin
         vstb_r <= 1'b0;
         unique case (st_r)
            ptt_pkg::ST_IDLE: begin
               step_cnt_r <= 16'h0000;
               tgt_r      <= tgt;
               if (tgt > ratio_r) begin
                  st_r <= ptt_pkg::ST_VUP; // R07
               end else if (tgt < ratio_r) begin
                  st_r <= ptt_pkg::ST_FREQ; // R08
               end
            end
            ptt_pkg::ST_VUP: begin
               if (step_cnt_r == 16'(VST_CYC - 1)) begin
                  step_cnt_r <= 16'h0000;
                  if (vcode_r < vc_of(tgt_r)) begin
                     vcode_r <= vcode_r + 8'h01; // R09 R10
                     vstb_r  <= 1'b1;
                  end else begin
                     st_r <= ptt_pkg::ST_FREQ; // R07
                  end
               end else begin
                  step_cnt_r <= step_cnt_r + 16'h0001;
               end
            end
            ptt_pkg::ST_FREQ: begin
               if (step_cnt_r == 16'(FST_CYC - 1)) begin
                  step_cnt_r <= 16'h0000;
                  ratio_r    <= tgt_r;
                  if (vcode_r > vc_of(tgt_r)) begin
                     st_r <= ptt_pkg::ST_VDN; // R08
                  end else begin
                     st_r <= ptt_pkg::ST_IDLE;
                  end
               end else begin
                  step_cnt_r <= step_cnt_r + 16'h0001;
               end
            end
            ptt_pkg::ST_VDN: begin
               if (step_cnt_r == 16'(VST_CYC - 1)) begin
                  step_cnt_r <= 16'h0000;
                  if (vcode_r > vc_of(tgt_r)) begin
                     vcode_r <= vcode_r - 8'h01; // R09
                     vstb_r  <= 1'b1;
                  end else begin
                     st_r <= ptt_pkg::ST_IDLE;
                  end
               end else begin
                  step_cnt_r <= step_cnt_r + 16'h0001;
               end
            end
         endcase
      end
   end

   // Modulation only once the lowest point is fully reached
   assign mod_en = ctl_r && (therm_ratio_r == `PTT_RATIO_MIN) &&
                   (ratio_r == `PTT_RATIO_MIN) &&
                   (st_r == ptt_pkg::ST_IDLE); // R14 R17

   // Counted in reference cycles, so core ratio never affects it
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mod_cnt_r <= 11'h000;
         clk_run_r <= 1'b1;
      end else if (!mod_en) begin
         mod_cnt_r <= 11'h000;
         clk_run_r <= 1'b1;
      end else begin
         if (mod_cnt_r == 11'(MOD_CYC - 1)) begin
            mod_cnt_r <= 11'h000; // R16
         end else begin
            mod_cnt_r <= mod_cnt_r + 11'h001;
         end
         clk_run_r <= (mod_cnt_r < 11'(ON_CYC)); // R15
      end
   end

   // Status vectors: {thr2, thr1, out of spec, hot}
   assign core_st = {core_rel_temp_in <= thr2_in,
                     core_rel_temp_in <= thr1_in,
                     mod_en && core_rel_temp_in == 7'h00, hot_r};
   assign pkg_st  = {pkg_rel <= thr2_in, pkg_rel <= thr1_in,
                     mod_en && pkg_rel == 7'h00, hot_r};

   // Log bits clear on a written zero; a written one leaves them
   assign core_clr = (msr_wr_in && msr_idx_in == `PTT_IDX_CORE_STAT) ?
      ~{msr_wdata_in[`PTT_B_THR2_LOG], msr_wdata_in[`PTT_B_THR1_LOG],
        msr_wdata_in[`PTT_B_OOS_LOG], msr_wdata_in[`PTT_B_HOT_LOG]} :
      4'h0;
   assign pkg_clr  = (msr_wr_in && msr_idx_in == `PTT_IDX_PKG_STAT) ?
      ~{msr_wdata_in[`PTT_B_THR2_LOG], msr_wdata_in[`PTT_B_THR1_LOG],
        msr_wdata_in[`PTT_B_OOS_LOG], msr_wdata_in[`PTT_B_HOT_LOG]} :
      4'h0;

   // A new event in the clearing cycle keeps its log bit set
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core_prev_r <= 4'h0;
         pkg_prev_r  <= 4'h0;
         core_log_r  <= 4'h0;
         pkg_log_r   <= 4'h0;
         thr_int_r   <= 1'b0;
      end else begin
         core_prev_r <= core_st;
         pkg_prev_r  <= pkg_st;
         core_log_r  <= (core_st & ~core_prev_r) |
                        (core_log_r & ~core_clr); // R23
         pkg_log_r   <= (pkg_st & ~pkg_prev_r) |
                        (pkg_log_r & ~pkg_clr); // R23
         thr_int_r   <= |(core_st[3:2] ^ core_prev_r[3:2]); // R22
      end
   end

   // Sideband value: mean of 256 evenly spaced samples of the hottest
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         smp_cnt_r <= 32'h0000_0000;
         smp_idx_r <= 8'h00;
         acc_r     <= 15'h0000;
         avg_r     <= 7'h00;
      end else if (smp_cnt_r == 32'(AVG_SAMPLE_CYC - 1)) begin
         smp_cnt_r <= 32'h0000_0000;
         smp_idx_r <= smp_idx_r + 8'h01;
         if (smp_idx_r == 8'hff) begin
            avg_r <= 7'((acc_r + {8'h00, pkg_rel}) >> 8); // R19
            acc_r <= 15'h0000;
         end else begin
            acc_r <= acc_r + {8'h00, pkg_rel};
         end
      end else begin
         smp_cnt_r <= smp_cnt_r + 32'h0000_0001;
      end
   end

   // Register read mux; readouts are relative, so never above the limit
   always_comb begin
      rdata_nxt = 64'h0;
      err_nxt   = 1'b0;
      unique case (msr_idx_in)
         `PTT_IDX_CORE_STAT: begin
            rdata_nxt[`PTT_B_HOT]      = core_st[0];
            rdata_nxt[`PTT_B_HOT_LOG]  = core_log_r[0];
            rdata_nxt[`PTT_B_OOS]      = core_st[1];
            rdata_nxt[`PTT_B_OOS_LOG]  = core_log_r[1];
            rdata_nxt[`PTT_B_THR1]     = core_st[2];
            rdata_nxt[`PTT_B_THR1_LOG] = core_log_r[2];
            rdata_nxt[`PTT_B_THR2]     = core_st[3];
            rdata_nxt[`PTT_B_THR2_LOG] = core_log_r[3];
            rdata_nxt[`PTT_B_RD_HI:`PTT_B_RD_LO] =
               core_rel_temp_in; // R19 R20
            rdata_nxt[`PTT_B_VALID]    = 1'b1;
         end
         `PTT_IDX_PKG_STAT: begin
            rdata_nxt[`PTT_B_HOT]      = pkg_st[0];
            rdata_nxt[`PTT_B_HOT_LOG]  = pkg_log_r[0];
            rdata_nxt[`PTT_B_OOS]      = pkg_st[1];
            rdata_nxt[`PTT_B_OOS_LOG]  = pkg_log_r[1];
            rdata_nxt[`PTT_B_THR1]     = pkg_st[2];
            rdata_nxt[`PTT_B_THR1_LOG] = pkg_log_r[2];
            rdata_nxt[`PTT_B_THR2]     = pkg_st[3];
            rdata_nxt[`PTT_B_THR2_LOG] = pkg_log_r[3];
            rdata_nxt[`PTT_B_RD_HI:`PTT_B_RD_LO] = pkg_rel; // R20
         end
         `PTT_IDX_TEMP_TGT: begin
            rdata_nxt[`PTT_B_TJ_HI:`PTT_B_TJ_LO] = `PTT_TJ_MAX; // R05
            err_nxt = msr_wr_in; // R05
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= 64'h0;
         ack_r   <= 1'b0;
         err_r   <= 1'b0;
      end else begin
         ack_r   <= msr_rd_in | msr_wr_in;
         err_r   <= (msr_rd_in | msr_wr_in) & err_nxt;
         rdata_r <= msr_rd_in ? rdata_nxt : 64'h0;
      end
   end

   assign msr_rdata_out         = rdata_r;
   assign msr_ack_out           = ack_r;
   assign msr_err_out           = err_r;
   assign package_hot_n_out     = ~hot_r; // R01
   assign ctl_active_out        = ctl_r;
   assign ratio_out             = ratio_r;
   assign voltage_step_code_out = vcode_r;
   assign vcode_strobe_out      = vstb_r;
   // Only frequency moves stall; snoops and interrupts are never held
   assign core_stall_out        = (st_r == ptt_pkg::ST_FREQ); // R11 R18
   assign clk_run_out           = clk_run_r;
   assign pstate_deferred_out   = ctl_r && (os_ratio_r > therm_ratio_r);
   assign thr_int_out           = thr_int_r;
   assign sideband_temp_out     = avg_r;

endmodule : ptt_throttle

// *** verification/ptt_vreg_model.sv ***
/*
 Model of the external regulator that takes voltage step codes.
 Assumes one code per strobe, on the block's own clock.
*/
`timescale 1ns/1ns
module ptt_vreg_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] code_in,
   input  wire logic       strobe_in,
   output logic [7:0]      code_out,
   output int              bad_steps_out
);
   // Starts at the code of the top ratio, where the block leaves reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         code_out <= 8'h70;
      end else if (strobe_in) begin
         code_out <= code_in;
      end
   end

   // A jump of more than one code would upset a real regulator
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bad_steps_out <= 0;
      end else if (strobe_in && code_in != code_out + 8'h01
                   && code_in != code_out - 8'h01) begin
         bad_steps_out <= bad_steps_out + 1;
      end
   end
endmodule : ptt_vreg_model

// *** verification/ptt_throttle_sva.sv ***
/*
 Port checker of the package thermal throttle.
 Assumes the single reference clock and its active-low reset.
*/
`timescale 1ns/1ns
module ptt_throttle_sva (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic [6:0]  core_rel_temp_in,
   input wire logic [6:0]  gfx_rel_temp_in,
   input wire logic [6:0]  act_offset_in,
   input wire logic        msr_rd_in,
   input wire logic [11:0] msr_idx_in,
   input wire logic [63:0] msr_rdata_out,
   input wire logic        msr_ack_out,
   input wire logic        msr_err_out,
   input wire logic        package_hot_n_out,
   input wire logic        ctl_active_out,
   input wire logic [5:0]  ratio_out,
   input wire logic [7:0]  voltage_step_code_out,
   input wire logic        vcode_strobe_out,
   input wire logic        core_stall_out,
   input wire logic        clk_run_out,
   input wire logic        pstate_deferred_out
);
   logic [6:0]  pkg_temp;
   logic [15:0] cool_cnt_r;
   logic [15:0] low_cnt_r;

   // The hotter sensor gives the smaller relative reading
   assign pkg_temp = (core_rel_temp_in < gfx_rel_temp_in) ?
                     core_rel_temp_in : gfx_rel_temp_in;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cool_cnt_r <= 16'h0000;
      end else begin
         cool_cnt_r <= package_hot_n_out ? cool_cnt_r + 16'h0001 : 16'h0000;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_cnt_r <= 16'h0000;
      end else begin
         low_cnt_r <= clk_run_out ? 16'h0000 : low_cnt_r + 16'h0001;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_hot_set;
      (pkg_temp <= act_offset_in) |=> !package_hot_n_out;
   endproperty
   a_hot_set: assert property (p_hot_set)
      else $error("hot indication missing at limit");

   property p_hot_hold;
      !package_hot_n_out |=> ctl_active_out;
   endproperty
   a_hot_hold: assert property (p_hot_hold)
      else $error("control not engaged while hot");

   // Small window: the exact edge of the count is the designer's
   property p_hyst;
      $fell(ctl_active_out) |-> cool_cnt_r inside {[16'h01f3:16'h01f6]};
   endproperty
   a_hyst: assert property (p_hyst)
      else $error("control released before hysteresis");

   property p_stall;
      $rose(core_stall_out) |-> ##9 core_stall_out ##1 !core_stall_out;
   endproperty
   a_stall: assert property (p_stall)
      else $error("frequency stall of wrong length");

   property p_no_vstep;
      core_stall_out |-> !vcode_strobe_out;
   endproperty
   a_no_vstep: assert property (p_no_vstep)
      else $error("voltage step during frequency change");

   property p_down;
      $changed(ratio_out) && ratio_out < $past(ratio_out) |->
         voltage_step_code_out == 8'h20 + {1'b0, $past(ratio_out), 1'b0};
   endproperty
   a_down: assert property (p_down)
      else $error("voltage moved before frequency on the way down");

   property p_up;
      $changed(ratio_out) && ratio_out > $past(ratio_out) |->
         voltage_step_code_out == 8'h20 + {1'b0, ratio_out, 1'b0};
   endproperty
   a_up: assert property (p_up)
      else $error("frequency raised before voltage");

   property p_step;
      $changed(voltage_step_code_out) |-> vcode_strobe_out &&
         (voltage_step_code_out == $past(voltage_step_code_out) + 8'h01 ||
          voltage_step_code_out == $past(voltage_step_code_out) - 8'h01);
   endproperty
   a_step: assert property (p_step)
      else $error("voltage code jumped");

   property p_mod_off;
      $rose(clk_run_out) && ctl_active_out |-> low_cnt_r == 16'h04b0;
   endproperty
   a_mod_off: assert property (p_mod_off)
      else $error("clock gated for wrong time");

   property p_limit;
      msr_rd_in && msr_idx_in == 12'h1a2 |=> msr_ack_out && !msr_err_out
         && msr_rdata_out[23:16] == 8'h64;
   endproperty
   a_limit: assert property (p_limit)
      else $error("limit register read wrong");

   property p_defer;
      pstate_deferred_out |-> ctl_active_out;
   endproperty
   a_defer: assert property (p_defer)
      else $error("request deferred without thermal control");
endmodule : ptt_throttle_sva

bind ptt_throttle ptt_throttle_sva u_sva (.ref_clk_in, .rst_n_in,
   .core_rel_temp_in, .gfx_rel_temp_in, .act_offset_in, .msr_rd_in,
   .msr_idx_in, .msr_rdata_out, .msr_ack_out, .msr_err_out,
   .package_hot_n_out, .ctl_active_out, .ratio_out,
   .voltage_step_code_out, .vcode_strobe_out, .core_stall_out,
   .clk_run_out, .pstate_deferred_out);

// *** verification/tb_top.sv ***
/*
 Testbench of the package thermal throttle: registers, thresholds,
 offset, full throttle down to clock modulation and recovery.
 Assumes the regulator model and the bound checker.
*/
`timescale 1ns/1ns
module tb_top;
   logic        clk, rst_n, req, rd, wr, e;
   logic [6:0]  core_t, gfx_t, offs, thr1, thr2, sband;
   logic [5:0]  rat, ratio;
   logic [11:0] idx;
   logic [63:0] wd, rdata, d;
   logic        ack, err, hot_n, ctl, strobe, stall, run, defer, tint;
   logic [7:0]  vcode, vreg_code;
   int          bad, n, fail_count, n_checks;

   ptt_throttle #(.AVG_SAMPLE_CYC(4)) DUT (
      .ref_clk_in(clk), .rst_n_in(rst_n), .core_rel_temp_in(core_t),
      .gfx_rel_temp_in(gfx_t), .act_offset_in(offs), .thr1_in(thr1),
      .thr2_in(thr2), .pstate_req_in(req), .pstate_ratio_in(rat),
      .msr_rd_in(rd), .msr_wr_in(wr), .msr_idx_in(idx),
      .msr_wdata_in(wd), .msr_rdata_out(rdata), .msr_ack_out(ack),
      .msr_err_out(err), .package_hot_n_out(hot_n),
      .ctl_active_out(ctl), .ratio_out(ratio),
      .voltage_step_code_out(vcode), .vcode_strobe_out(strobe),
      .core_stall_out(stall), .clk_run_out(run),
      .pstate_deferred_out(defer), .thr_int_out(tint),
      .sideband_temp_out(sband));
   ptt_vreg_model u_vreg (.clk_in(clk), .rst_n_in(rst_n),
      .code_in(vcode), .strobe_in(strobe), .code_out(vreg_code),
      .bad_steps_out(bad));

   always #10 clk = ~clk;

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [63:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time,
                  what, got, exp);
      end
   endtask : chk

   task automatic msr(input logic w, input logic [11:0] i,
                      input logic [63:0] wv);
      cyc(1);
      rd = !w;
      wr = w;
      idx = i;
      wd = wv;
      cyc(1);
      rd = 1'b0;
      wr = 1'b0;
      chk(ack, 1'b1, "ack");
      d = rdata;
      e = err;
   endtask : msr

   task automatic preq(input logic [5:0] r);
      req = 1'b1;
      rat = r;
      cyc(1);
      req = 1'b0;
   endtask : preq

   task automatic wait_ratio(input logic [5:0] r, input int lim);
      for (int i = 0; i < lim && ratio !== r; i++) cyc(1);
      chk(ratio, r, "ratio");
   endtask : wait_ratio

   // Bounded so a stuck level cannot hang the run
   task automatic hold_len(input int sel, input logic v);
      n = 0;
      while ((sel == 0 ? ctl : sel == 1 ? run : tint) === v && n < 5000) begin
         n++;
         cyc(1);
      end
   endtask : hold_len

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic t_reset;
      chk({hot_n, ctl, run, stall}, 4'b1010, "reset flags");
      chk({ratio, vcode}, {6'h28, 8'h70}, "reset point");
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      msr(1'b0, 12'h1a2, 64'h0);
      chk({e, d[23:16]}, 9'h064, "limit read");
      msr(1'b1, 12'h1a2, 64'h0);
      chk(e, 1'b1, "limit write refused");
      msr(1'b0, 12'h1a2, 64'h0);
      chk(d[23:16], 8'h64, "limit kept");
      msr(1'b0, 12'h123, 64'h0);
      chk({e, |d}, 2'b10, "unmapped");
      msr(1'b0, 12'h19c, 64'h0);
      chk({d[31], d[22:16], d[0]}, 9'h160, "core reading");
      cyc(2100);
      chk(sband, 7'h30, "sideband average");
      $display("test registers done");
   endtask : t_regs

   task automatic t_thr;
      core_t = 7'h18;
      hold_len(2, 1'b0);
      chk(tint, 1'b1, "threshold event");
      msr(1'b0, 12'h19c, 64'h0);
      chk({d[9:6], hot_n}, 5'b00111, "threshold set");
      core_t = 7'h30;
      msr(1'b0, 12'h19c, 64'h0);
      chk(d[9:6], 4'b0010, "log sticky");
      msr(1'b1, 12'h19c, 64'h0);
      msr(1'b0, 12'h19c, 64'h0);
      chk(d[9:6], 4'b0000, "log cleared");
      $display("test thresholds done");
   endtask : t_thr

   task automatic t_offset;
      offs = 7'h10;
      gfx_t = 7'h10;
      cyc(3);
      chk({hot_n, ctl}, 2'b01, "offset engage");
      gfx_t = 7'h30;
      hold_len(0, 1'b1);
      chk(n >= 500 && n <= 505, 1'b1, "hysteresis");
      offs = 7'h00;
      $display("test offset done");
   endtask : t_offset

   task automatic t_throttle;
      core_t = 7'h00;
      cyc(3);
      chk({hot_n, ctl}, 2'b01, "engage at zero");
      preq(6'h20);
      chk(defer, 1'b0, "lower request");
      wait_ratio(6'h20, 1500);
      cyc(9000);
      preq(6'h28);
      cyc(2);
      chk(defer, 1'b1, "higher request");
      wait_ratio(6'h08, 40000);
      msr(1'b0, 12'h1b1, 64'h0);
      chk(d[0], 1'b1, "package hot");
      hold_len(1, 1'b1);
      chk(run, 1'b0, "modulation start");
      hold_len(1, 1'b0);
      chk(n, 1200, "clock off time");
      hold_len(1, 1'b1);
      chk(n, 400, "clock on time");
      msr(1'b0, 12'h1b1, 64'h0);
      chk(d[5:4], 2'b11, "out of spec");
      chk({vreg_code, bad}, {8'h30, 32'h0}, "regulator");
      core_t = 7'h30;
      wait_ratio(6'h28, 20000);
      chk({ctl, run, defer}, 3'b010, "recovered");
      chk(vcode, 8'h70, "voltage restored");
      $display("test throttle done");
   endtask : t_throttle

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      req = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      rat = 6'h28;
      idx = 12'h000;
      wd = 64'h0;
      core_t = 7'h30;
      gfx_t = 7'h30;
      offs = 7'h00;
      thr1 = 7'h20;
      thr2 = 7'h10;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_thr();
      t_offset();
      t_throttle();
      end_of_test();
   end

   // About two and a half times the expected run
   initial begin
      #2000000;
      fail_count++;
      end_of_test();
   end
endmodule : tb_top
